// >>> fhds_operator_model.sv
// operator pushbutton model that drives the fault reset input
module fhds_operator_model (
  input  wire logic sys_clk,
  output logic      faultResetInput
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // pushbutton
  // ==========================================================
  // released at time zero, so the design can arm itself
  initial faultResetInput = 1'b0;

  // press held for n whole cycles, changed only at rising edges
  // hold input continuous
  task automatic press(input int n);
    @(posedge sys_clk) faultResetInput <= 1'b1;
    repeat (n) @(posedge sys_clk);
    faultResetInput <= 1'b0;
  endtask : press
endmodule : fhds_operator_model

// >>> fhds_pkg.sv
// shared constants and types of the fault history display sequencer
package fhds_pkg;

  // ==========================================================
  // clock and times
  // ==========================================================
  localparam int CLK_HZ     = 10_000_000;        // sys_clk rate
  localparam int CYC_PER_MS = CLK_HZ / 1000;     // cycles in one millisecond
  localparam int HOLD_MS    = 2000;              // reset hold before playback
  localparam int CODE_MS    = 4000;              // fault code shown this long
  localparam int DASH_MS    = 1000;              // dash separator shown this long
  localparam int ZERO_MS    = 500;               // zero signal must drop within this
  localparam int HOLD_CYC   = HOLD_MS * CYC_PER_MS;
  localparam int CODE_CYC   = CODE_MS * CYC_PER_MS;
  localparam int DASH_CYC   = DASH_MS * CYC_PER_MS;
  localparam int ZERO_CYC   = ZERO_MS * CYC_PER_MS;

  // ==========================================================
  // widths and sizes
  // ==========================================================
  localparam int HIST_DEPTH = 10;                // entries in the history store
  localparam int NUM_FAULTS = 4;                 // fault sources feeding the log
  localparam int CNT_W      = 32;                // timer counter width

  // ==========================================================
  // fault sources, codes and display values
  // ==========================================================
  localparam int F_OVERLOAD = 0;                 // load cell current below 4 mA
  localparam int F_ZERO_POS = 1;                 // zero position stuck
  localparam int F_PHASE2   = 2;                 // phase two missing
  localparam int F_PHASE3   = 3;                 // phase three missing
  // two bcd digits per code, index = fault source
  localparam logic [NUM_FAULTS-1:0][7:0] FAULT_CODES = {8'h13, 8'h12, 8'h45, 8'h49};
  localparam logic [7:0] DASH_CODE  = 8'haa;     // both digits as dash segments
  localparam logic [7:0] HIST_RESET = 8'h00;     // empty history slot
  localparam logic [3:0] COUNT_MAX  = 4'ha;      // history count when full

  // ==========================================================
  // status word layout, low bit of each group
  // ==========================================================
  localparam int SW_FAULT_LSB = 0;               // 4 fault flags
  localparam int SW_IN_LSB    = 4;               // 6 physical inputs
  localparam int SW_OUT_LSB   = 10;              // 2 physical outputs

  // playback sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CODE = 3'b010,
    ST_DASH = 3'b100
  } fhds_state_t;

endpackage : fhds_pkg

// >>> fhds_sequencer.sv
// fault logging, history playback on the two-digit display and status packing
// How it works
// - no active fault: display shows version code
// - keep ten newest fault codes, newest first
// - reset held over two seconds starts playback
// - newest code, dash, older codes, then version
// - code shown four seconds, dash one second
// - load current below 4 mA logs 49
// - zero signal stuck after leaving neutral logs 45
// - phase two and three flags never swapped
// - pack flags and pins into 16-bit word
// - clear faults only with switch in neutral
module fhds_sequencer #(
  parameter logic [7:0] VERSION_CODE = 8'h17,            // arbitrary value
  parameter int         HOLD_CYC     = fhds_pkg::HOLD_CYC,
  parameter int         CODE_CYC     = fhds_pkg::CODE_CYC,
  parameter int         DASH_CYC     = fhds_pkg::DASH_CYC,
  parameter int         ZERO_CYC     = fhds_pkg::ZERO_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        faultResetInput,
  input  wire logic        masterNeutral,
  input  wire logic        zeroPosition,
  input  wire logic        analogLoadInputLow,
  input  wire logic        phaseTwoMissingIn,
  input  wire logic        phaseThreeMissingIn,
  output logic [7:0]       dispCode,
  output logic             dispDash,
  output logic             overloadWarning,
  output logic             zeroPositionFault,
  output logic             phaseTwoMissingFault,
  output logic             phaseThreeMissingFault,
  output logic             playbackActive,
  output logic [15:0]      statusWord
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // timers
  // ==========================================================
  fhds_timer_if holdTmr ();   // reset button hold
  fhds_timer_if phaseTmr ();  // code and dash intervals
  fhds_timer_if zeroTmr ();   // zero position check

  fhds_timer u_hold  (.sys_clk(sys_clk), .nrst(nrst), .tmr(holdTmr));
  fhds_timer u_phase (.sys_clk(sys_clk), .nrst(nrst), .tmr(phaseTmr));
  fhds_timer u_zero  (.sys_clk(sys_clk), .nrst(nrst), .tmr(zeroTmr));

  // ==========================================================
  // state
  // ==========================================================
  logic [3:0]            faultActive, next_faultActive;   // active fault flags
  logic [3:0]            srcPrev,     next_srcPrev;       // sources last cycle
  logic [3:0]            pending,     next_pending;       // codes not yet logged
  logic                  zeroDone,    next_zeroDone;      // check done this excursion
  logic [7:0]            hist [fhds_pkg::HIST_DEPTH];     // newest at slot 0
  logic [7:0]            next_hist [fhds_pkg::HIST_DEPTH];
  logic [3:0]            histCount,   next_histCount;     // valid entries
  fhds_pkg::fhds_state_t state,       next_state;         // playback state
  logic [3:0]            idx,         next_idx;           // entry on display
  logic                  armed,       next_armed;         // button released since last start
  logic [7:0]            next_dispCode;
  logic                  next_dispDash;
  logic [15:0]           next_statusWord;
  logic [3:0]            src;                              // fault source levels
  logic                  clrReq;                           // accepted clear request
  logic [7:0]            selCode;                          // code logged this cycle
  logic [7:0]            actCode;                          // code of an active fault

  // ==========================================================
  // fault sources and flags
  // ==========================================================
  // zero check runs once per excursion out of neutral
  // timer on stuck zero
  assign zeroTmr.run   = !masterNeutral && zeroPosition && !zeroDone;
  assign zeroTmr.limit = 32'(ZERO_CYC - 1);

  // each source keeps its own slot, the phase inputs are not crossed
  // straight mapping
  assign src = {phaseThreeMissingIn, phaseTwoMissingIn, zeroTmr.expired, analogLoadInputLow};

  // a press outside neutral is simply dropped
  // neutral gates clear
  assign clrReq = faultResetInput && masterNeutral;

  // flags, edge memory and logging queue
  always_comb begin
    // all four flags set from their sources; set beats clear
    next_faultActive = (faultActive & ~{4{clrReq}}) | src;
    next_srcPrev     = src;
    next_zeroDone    = masterNeutral ? 1'b0 : (zeroDone || zeroTmr.expired);
    next_pending     = pending | (src & ~srcPrev);
    selCode          = fhds_pkg::HIST_RESET;
    // lowest pending source goes first, one per cycle
    for (int i = fhds_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        selCode = fhds_pkg::FAULT_CODES[i];
      end
    end
    for (int i = 0; i < fhds_pkg::NUM_FAULTS; i++) begin
      if (pending[i] && selCode == fhds_pkg::FAULT_CODES[i]) begin
        next_pending[i] = src[i] && !srcPrev[i];
      end
    end
  end

  // ==========================================================
  // history store
  // ==========================================================
  // shift newest into slot 0, oldest falls out
  always_comb begin
    for (int k = 0; k < fhds_pkg::HIST_DEPTH; k++) begin
      next_hist[k] = hist[k];
    end
    next_histCount = histCount;
    if (pending != 4'h0) begin
      next_hist[0] = selCode;
      for (int k = 1; k < fhds_pkg::HIST_DEPTH; k++) begin
        next_hist[k] = hist[k-1];
      end
      if (histCount != fhds_pkg::COUNT_MAX) begin
        next_histCount = histCount + 4'h1;
      end
    end
  end

  // ==========================================================
  // playback sequencer
  // ==========================================================
  // hold must run past the full two seconds
  assign holdTmr.run   = faultResetInput && armed && (state == fhds_pkg::ST_IDLE);
  assign holdTmr.limit = 32'(HOLD_CYC);

  assign phaseTmr.run   = (state != fhds_pkg::ST_IDLE);
  assign phaseTmr.limit = (state == fhds_pkg::ST_CODE) ? 32'(CODE_CYC - 1) : 32'(DASH_CYC - 1);

  // next state; logging during playback shifts entries under the display
  always_comb begin
    next_state = state;
    next_idx   = idx;
    // one start per press, a held button must be released first
    next_armed = faultResetInput ? (armed && !holdTmr.expired) : 1'b1;
    case (state)
      fhds_pkg::ST_IDLE: begin
        // start on hold expiry, empty store shows nothing
        if (holdTmr.expired && histCount != 4'h0) begin
          next_state = fhds_pkg::ST_CODE;
          next_idx   = 4'h0;
        end
      end
      fhds_pkg::ST_CODE: begin
        // every code is followed by a dash
        if (phaseTmr.expired) begin
          next_state = fhds_pkg::ST_DASH;
        end
      end
      fhds_pkg::ST_DASH: begin
        if (phaseTmr.expired) begin
          // stop after the oldest stored entry
          if (4'(idx + 4'h1) >= histCount) begin
            next_state = fhds_pkg::ST_IDLE;
          end else begin
            next_state = fhds_pkg::ST_CODE;
            next_idx   = idx + 4'h1;
          end
        end
      end
      default: begin
        next_state = fhds_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // display and status word
  // ==========================================================
  always_comb begin
    actCode = fhds_pkg::HIST_RESET;
    for (int i = fhds_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
      if (faultActive[i]) begin
        actCode = fhds_pkg::FAULT_CODES[i];
      end
    end
    next_dispDash = 1'b0;
    if (state == fhds_pkg::ST_CODE) begin
      next_dispCode = hist[idx];
    end else if (state == fhds_pkg::ST_DASH) begin
      next_dispCode = fhds_pkg::DASH_CODE;
      next_dispDash = 1'b1;
    end else if (faultActive != 4'h0) begin
      next_dispCode = actCode;
    end else begin
      next_dispCode = VERSION_CODE;
    end
    // flags, inputs and outputs in one word
    next_statusWord = 16'h0000;
    next_statusWord[fhds_pkg::SW_FAULT_LSB +: 4] = faultActive;
    next_statusWord[fhds_pkg::SW_IN_LSB +: 6]    = {phaseThreeMissingIn, phaseTwoMissingIn, zeroPosition,
                                                    masterNeutral, faultResetInput, analogLoadInputLow};
    next_statusWord[fhds_pkg::SW_OUT_LSB +: 2]   = {dispDash, playbackActive};
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      faultActive <= 4'h0;
      srcPrev     <= 4'h0;
      pending     <= 4'h0;
      zeroDone    <= 1'b0;
      histCount   <= 4'h0;
      state       <= fhds_pkg::ST_IDLE;
      idx         <= 4'h0;
      armed       <= 1'b0;   // a button held through reset does not start playback
      dispCode    <= VERSION_CODE;
      dispDash    <= 1'b0;
      statusWord  <= 16'h0000;
      for (int k = 0; k < fhds_pkg::HIST_DEPTH; k++) begin
        hist[k] <= fhds_pkg::HIST_RESET;
      end
    end else begin
      faultActive <= next_faultActive;
      srcPrev     <= next_srcPrev;
      pending     <= next_pending;
      zeroDone    <= next_zeroDone;
      histCount   <= next_histCount;
      state       <= next_state;
      idx         <= next_idx;
      armed       <= next_armed;
      dispCode    <= next_dispCode;
      dispDash    <= next_dispDash;
      statusWord  <= next_statusWord;
      for (int k = 0; k < fhds_pkg::HIST_DEPTH; k++) begin
        hist[k] <= next_hist[k];
      end
    end
  end

  assign overloadWarning        = faultActive[fhds_pkg::F_OVERLOAD];
  assign zeroPositionFault      = faultActive[fhds_pkg::F_ZERO_POS];
  assign phaseTwoMissingFault   = faultActive[fhds_pkg::F_PHASE2];
  assign phaseThreeMissingFault = faultActive[fhds_pkg::F_PHASE3];
  assign playbackActive         = (state != fhds_pkg::ST_IDLE);

  // ==========================================================
  // checks
  // ==========================================================
  logic [31:0] stateAge;  // cycles spent in the current state, helper only
  always_ff @(posedge sys_clk) begin
    if (!nrst || next_state != state) begin
      stateAge <= 32'h0;
    end else begin
      stateAge <= stateAge + 32'h1;
    end
  end

  property p_version_shown;
    (state == fhds_pkg::ST_IDLE && faultActive == 4'h0) |=> (dispCode == VERSION_CODE && !dispDash);
  endproperty
  a_version_shown: assert property (p_version_shown) else $error("version code missing");

  property p_history_push;
    (pending != 4'h0) |=> (hist[0] == $past(selCode) && hist[1] == $past(hist[0]));
  endproperty
  a_history_push: assert property (p_history_push) else $error("history shift wrong");

  sequence s_hold_done;
    faultResetInput && armed && state == fhds_pkg::ST_IDLE && holdTmr.count == 32'(HOLD_CYC);
  endsequence
  sequence s_first_entry;
    state == fhds_pkg::ST_CODE && idx == 4'h0 ##1 dispCode == hist[0];
  endsequence
  property p_playback_start;
    s_hold_done ##0 (histCount != 4'h0) |=> s_first_entry;
  endproperty
  a_playback_start: assert property (p_playback_start) else $error("playback did not start");

  property p_no_early_start;
    (state == fhds_pkg::ST_IDLE ##1 state == fhds_pkg::ST_CODE) |-> $past(holdTmr.count) == 32'(HOLD_CYC);
  endproperty
  a_no_early_start: assert property (p_no_early_start) else $error("playback started early");

  property p_dash_after_code;
    (state == fhds_pkg::ST_CODE && phaseTmr.expired) |=> state == fhds_pkg::ST_DASH ##1 dispDash;
  endproperty
  a_dash_after_code: assert property (p_dash_after_code) else $error("dash missing");

  property p_next_entry;
    (state == fhds_pkg::ST_DASH && phaseTmr.expired && 4'(idx + 4'h1) < histCount)
      |=> (state == fhds_pkg::ST_CODE && idx == 4'($past(idx) + 4'h1));
  endproperty
  a_next_entry: assert property (p_next_entry) else $error("entry order wrong");

  property p_phase_time;
    phaseTmr.expired |-> stateAge == ((state == fhds_pkg::ST_CODE) ? 32'(CODE_CYC - 1) : 32'(DASH_CYC - 1));
  endproperty
  a_phase_time: assert property (p_phase_time) else $error("phase duration wrong");

  property p_overload;
    analogLoadInputLow |=> (overloadWarning && statusWord[fhds_pkg::SW_IN_LSB] == 1'b1)
      ##1 (overloadWarning || $past(clrReq));
  endproperty
  a_overload: assert property (p_overload) else $error("overload warning missing");

  property p_zero_fault;
    zeroTmr.expired |=> zeroPositionFault && (pending[fhds_pkg::F_ZERO_POS] || hist[0] == 8'h45);
  endproperty
  a_zero_fault: assert property (p_zero_fault) else $error("zero position fault missing");

  property p_phase_map;
    (!phaseThreeMissingIn && (!phaseThreeMissingFault || clrReq) && phaseTwoMissingIn)
      |=> (phaseTwoMissingFault && !phaseThreeMissingFault);
  endproperty
  a_phase_map: assert property (p_phase_map) else $error("phase flags crossed");

  property p_status_pack;
    1'b1 |=> statusWord[fhds_pkg::SW_IN_LSB + 5 -: 2] == $past({phaseThreeMissingIn, phaseTwoMissingIn});
  endproperty
  a_status_pack: assert property (p_status_pack) else $error("status word packing wrong");

  property p_clear_neutral_only;
    !masterNeutral |=> ((faultActive & $past(faultActive)) == $past(faultActive));
  endproperty
  a_clear_neutral_only: assert property (p_clear_neutral_only) else $error("fault cleared outside neutral");

  property p_short_history;
    (state == fhds_pkg::ST_DASH && phaseTmr.expired && 4'(idx + 4'h1) >= histCount)
      |=> state == fhds_pkg::ST_IDLE ##1 (dispDash == 1'b0);
  endproperty
  a_short_history: assert property (p_short_history) else $error("playback overran history");

endmodule : fhds_sequencer

// >>> fhds_timer.sv
// interval timer that counts while run and restarts on expiry
module fhds_timer (
  input wire logic     sys_clk,
  input wire logic     nrst,
  fhds_timer_if.timer  tmr
);

  // ==========================================================
  // counter
  // ==========================================================
  logic [31:0] cnt;       // cycles counted so far
  logic [31:0] next_cnt;  // next count

  // expiry and restart share one edge, so no idle cycle between phases
  always_comb begin
    tmr.expired = tmr.run && (cnt == tmr.limit);
    if (!tmr.run || tmr.expired) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 32'h1;
    end
  end

  // register only
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tmr.count = cnt;

  // count never passes its limit while running
  property p_cnt_bounded;
    @(posedge sys_clk) disable iff (!nrst) tmr.run |-> (cnt <= tmr.limit);
  endproperty
  a_cnt_bounded: assert property (p_cnt_bounded) else $error("timer count beyond limit");

endmodule : fhds_timer

// >>> fhds_timer_if.sv
// carrier between the sequencer and its interval timers
interface fhds_timer_if;
  logic        run;      // count while high, clear while low
  logic [31:0] limit;    // last count value before expiry
  logic        expired;  // count reached limit this cycle
  logic [31:0] count;    // current count
  modport timer (input run, input limit, output expired, output count);
  modport user  (output run, output limit, input expired, input count);
endinterface : fhds_timer_if

// >>> tb_fault_history_display_sequencer.sv
// self-checking bench of the fault history display sequencer
module tb_fault_history_display_sequencer;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // settings and signals
  // ==========================================================
  localparam logic [7:0] VER = 8'h17;  // arbitrary value
  localparam int HOLD = 20;            // short hold for a quick run
  localparam int CODE = 8;             // code display cycles
  localparam int DASH = 4;             // dash display cycles
  typedef struct {
    logic [8:0] v;                     // {dash, code}
    int         d;                     // cycles it lasts, 0 unchecked
  } fhds_note_t;
  logic        sys_clk;
  logic        nrst;
  logic        faultResetInput;
  logic        masterNeutral;
  logic        zeroPosition;
  logic        analogLoadInputLow;
  logic        phaseTwoMissingIn;
  logic        phaseThreeMissingIn;
  logic [7:0]  dispCode;
  logic        dispDash;
  logic        overloadWarning;
  logic        zeroPositionFault;
  logic        phaseTwoMissingFault;
  logic        phaseThreeMissingFault;
  logic        playbackActive;
  logic [15:0] statusWord;
  fhds_note_t  q[$];                   // expected display changes
  logic [7:0]  hist[$];                // expected history, newest first
  logic [8:0]  prev;                   // last display seen
  int          cnt;                    // cycles of the current display
  int          pd;                     // expected length of it
  int          error_cnt = 0;
  int          tests_run = 0;
  int          seed = 51808;
  int          k;

  localparam int ZERO = 5;             // zero check window cycles
  // version code stays at the design default, which VER mirrors
  fhds_sequencer #(.HOLD_CYC(HOLD), .CODE_CYC(CODE), .DASH_CYC(DASH), .ZERO_CYC(ZERO)) uut (
    .sys_clk                (sys_clk),
    .nrst                   (nrst),
    .faultResetInput        (faultResetInput),
    .masterNeutral          (masterNeutral),
    .zeroPosition           (zeroPosition),
    .analogLoadInputLow     (analogLoadInputLow),
    .phaseTwoMissingIn      (phaseTwoMissingIn),
    .phaseThreeMissingIn    (phaseThreeMissingIn),
    .dispCode               (dispCode),
    .dispDash               (dispDash),
    .overloadWarning        (overloadWarning),
    .zeroPositionFault      (zeroPositionFault),
    .phaseTwoMissingFault   (phaseTwoMissingFault),
    .phaseThreeMissingFault (phaseThreeMissingFault),
    .playbackActive         (playbackActive),
    .statusWord             (statusWord)
  );
  fhds_operator_model op (.sys_clk(sys_clk), .faultResetInput(faultResetInput));

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // let the edge updates land before looking
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task nt(input logic [8:0] v, input int d);
    q.push_back('{v, d});
  endtask : nt

  // one source pulse, logged, shown, then cleared in neutral
  task log_fault(input int s);
    logic [7:0] c;
    c = fhds_pkg::FAULT_CODES[s];
    nt({1'b0, c}, 0);
    @(posedge sys_clk) begin
      analogLoadInputLow  <= (s == 0);
      phaseTwoMissingIn   <= (s == 2);
      phaseThreeMissingIn <= (s == 3);
      // zero contact noise in neutral must log nothing
      zeroPosition        <= 1'($random(seed));
    end
    @(posedge sys_clk) begin
      analogLoadInputLow  <= 1'b0;
      phaseTwoMissingIn   <= 1'b0;
      phaseThreeMissingIn <= 1'b0;
    end
    tick(4);
    check(phaseTwoMissingFault, s == 2, "phase two flag");
    check(phaseThreeMissingFault, s == 3, "phase three flag");
    nt({1'b0, VER}, 0);
    op.press(1);
    tick(3);
    hist.push_front(c);
    if (hist.size() > 10) void'(hist.pop_back());
  endtask : log_fault

  // expected playback, then a long hold to start it
  task play();
    int n;
    for (int i = 0; i < hist.size(); i++) begin
      nt({1'b0, hist[i]}, CODE);
      nt({1'b1, fhds_pkg::DASH_CODE}, DASH);
    end
    nt({1'b0, VER}, 0);
    op.press(HOLD + 5);
    tick(1);
    // first code still up: playback on, dash off
    check(statusWord[fhds_pkg::SW_OUT_LSB +: 2], 2'b01, "status outputs");
    n = 0;
    while (playbackActive !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    check(playbackActive, 1'b0, "playback end");
  endtask : play

  task report_and_stop();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // clock, watchdog and display monitor
  // ==========================================================
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end

  // each display change takes the oldest note; lengths checked too
  always @(posedge sys_clk) begin
    #1;
    if (nrst !== 1'b1) prev = {dispDash, dispCode};
    else if ({dispDash, dispCode} !== prev) begin
      if (pd != 0) check(cnt, pd, "display time");
      if (q.size() == 0) check(0, 1, "unexpected display");
      else begin
        check({dispDash, dispCode}, q[0].v, "display");
        pd = q[0].d;
        void'(q.pop_front());
      end
      cnt = 1;
      prev = {dispDash, dispCode};
    end else cnt++;
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    nrst = 1'b0;
    masterNeutral = 1'b1;
    zeroPosition = 1'b0;
    analogLoadInputLow = 1'b0;
    phaseTwoMissingIn = 1'b0;
    phaseThreeMissingIn = 1'b0;
    pd = 0;
    cnt = 0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    tick(1);
    check(dispCode, VER, "version");
    // one edge after release the word already holds the neutral input
    check(statusWord, 16'h0040, "status reset");
    // empty history: long hold starts nothing
    op.press(HOLD + 5);
    tick(3);
    check(playbackActive, 1'b0, "empty start");
    // overload, then a clear outside neutral is ignored
    nt({1'b0, 8'h49}, 0);
    @(posedge sys_clk) analogLoadInputLow <= 1'b1;
    @(posedge sys_clk) analogLoadInputLow <= 1'b0;
    tick(4);
    check(overloadWarning, 1'b1, "overload");
    check(statusWord, 16'h0041, "status");
    @(posedge sys_clk) masterNeutral <= 1'b0;
    op.press(1);
    tick(3);
    check(overloadWarning, 1'b1, "clear refused");
    @(posedge sys_clk) masterNeutral <= 1'b1;
    nt({1'b0, VER}, 0);
    op.press(1);
    tick(3);
    check(overloadWarning, 1'b0, "clear");
    hist.push_front(8'h49);
    // both phases at once, flags kept apart
    nt({1'b0, 8'h12}, 0);
    @(posedge sys_clk) {phaseTwoMissingIn, phaseThreeMissingIn} <= 2'b11;
    @(posedge sys_clk) {phaseTwoMissingIn, phaseThreeMissingIn} <= 2'b00;
    tick(4);
    check(statusWord, 16'h004c, "phase flags");
    nt({1'b0, VER}, 0);
    op.press(1);
    tick(3);
    hist.push_front(8'h12);
    hist.push_front(8'h13);
    // zero signal stuck after leaving neutral
    nt({1'b0, 8'h45}, 0);
    @(posedge sys_clk) {masterNeutral, zeroPosition} <= 2'b01;
    tick(10);
    check(zeroPositionFault, 1'b1, "zero stuck");
    @(posedge sys_clk) {masterNeutral, zeroPosition} <= 2'b10;
    nt({1'b0, VER}, 0);
    op.press(1);
    tick(3);
    hist.push_front(8'h45);
    // four entries only
    play();
    // short hold is refused
    op.press(HOLD / 2);
    tick(15);
    check(playbackActive, 1'b0, "short hold");
    // overfill the history with random sources
    repeat (11) begin
      k = $unsigned($random(seed)) % 3;
      log_fault(k == 0 ? 0 : k + 1);
    end
    play();
    tick(5);
    check(q.size(), 0, "notes left");
    report_and_stop();
  end
endmodule : tb_fault_history_display_sequencer
